// [logic/tsbe_bit_shaper.v]
// one output level from pattern bit, bit phase and modulation settings
// assumes phase quarters and subcarrier level come from the caller
`timescale 1ns/10ps
`include "tsbe_defs.vh"
module tsbe_bit_shaper (
  bitVal,
  prevBit,
  quarter,
  scLevel,
  envSel,
  pulseSel,
  millerOn,
  rzAtStart,
  invertOn,
  level
);
  input  wire       bitVal;
  input  wire       prevBit;
  input  wire [1:0] quarter;
  input  wire       scLevel;
  input  wire [2:0] envSel;
  input  wire [1:0] pulseSel;
  input  wire       millerOn;
  input  wire       rzAtStart;
  input  wire       invertOn;
  output reg        level;

  reg secondHalf;
  reg envLevel;
  reg pulseLevel;

  always @* begin
    secondHalf = quarter[1];
    case (envSel)
      `TSBE_ENV_DIRECT:   envLevel = bitVal;
      `TSBE_ENV_MANCH:    envLevel = bitVal ^ secondHalf;
      `TSBE_ENV_MANCH_SC: envLevel = (bitVal ^ secondHalf) & scLevel;
      `TSBE_ENV_BPSK:     envLevel = bitVal ^ scLevel;
      `TSBE_ENV_RZ_HALF:  envLevel = bitVal & secondHalf;
      `TSBE_ENV_RZ_ALT:   envLevel = bitVal & (rzAtStart ? ~secondHalf
                                                       : secondHalf);
      default:            envLevel = 1'b0;
    endcase
    if (millerOn) begin
      // one: pulse mid-bit; zero after zero: pulse at start
      if (bitVal)
        pulseLevel = (quarter == 2'h2);
      else
        pulseLevel = ~prevBit & (quarter == 2'h0);
    end else begin
      case (pulseSel)
        `TSBE_PULSE_START: pulseLevel = envLevel & (quarter == 2'h0);
        `TSBE_PULSE_HALF:  pulseLevel = envLevel & (quarter == 2'h2);
        `TSBE_PULSE_Q3:    pulseLevel = envLevel & (quarter == 2'h3);
        default:           pulseLevel = envLevel;
      endcase
    end
    level = pulseLevel ^ invertOn;
  end
endmodule

// [logic/tsbe_defs.vh]
// constants of the transmit symbol burst and envelope stage
// assumes a 125 MHz core clock and byte-wide register access
// Notes on behaviour
// - bit 6 of burst control picks symbol one burst level, zero or one.
// - burst-only for symbol one sends just the burst, no pattern.
// - burst enable for symbol one prepends a burst of the set length.
// - bit 2 of burst control picks symbol zero burst level.
// - burst-only for symbol zero sends just the burst, no pattern.
// - burst enable for symbol zero prepends a burst of the shared length.
// - pair 0/1 Miller bit applies modified Miller; set only with pulse type 1.
// - pair 2/3 Miller bit applies modified Miller; set only with pulse type 1.
// - pulse type: 0 none, 1 bit start, 2 third quarter, 3 last quarter.
// - invert bit of pair 0/1 inverts output of symbols zero and one.
// - invert bit of pair 2/3 inverts output of symbols two and three.
// - pair 0/1 envelope: direct, Manchester, subcarrier, BPSK, 4/5 RZ.
// - pair 2/3 envelope as pair 0/1, but 5 puts RZ pulse at bit start.
// - pattern length field plus one gives valid pattern bits.
// - bit-rate codes 2 to 7 give 26 to 848 kHz, doubling; 0/1 reserved.
`ifndef TSBE_DEFS_VH
`define TSBE_DEFS_VH
`define TSBE_ADDR_FREQ      8'h4C
`define TSBE_ADDR_SYM0H     8'h4D
`define TSBE_ADDR_SYM0L     8'h4E
`define TSBE_ADDR_SYM1H     8'h4F
`define TSBE_ADDR_SYM1L     8'h50
`define TSBE_ADDR_SYM2      8'h51
`define TSBE_ADDR_SYM3      8'h52
`define TSBE_ADDR_LEN10     8'h53
`define TSBE_ADDR_LEN32     8'h54
`define TSBE_ADDR_BURST     8'h55
`define TSBE_ADDR_MOD10     8'h56
`define TSBE_ADDR_MOD32     8'h57
`define TSBE_MASK_LEN32     8'h77
`define TSBE_MASK_BURST     8'h77
`define TSBE_MASK_MOD       8'h7F
`define TSBE_RST_VAL        8'h00
`define TSBE_BIT_ON_S0      0
`define TSBE_BIT_ALONE_S0   1
`define TSBE_BIT_POL_S0     2
`define TSBE_BIT_ON_S1      4
`define TSBE_BIT_ALONE_S1   5
`define TSBE_BIT_POL_S1     6
`define TSBE_BIT_MILLER     6
`define TSBE_BIT_INVERT     3
`define TSBE_BIT_SC23       7
`define TSBE_BIT_SC01       3
`define TSBE_ENV_DIRECT     3'h0
`define TSBE_ENV_MANCH      3'h1
`define TSBE_ENV_MANCH_SC   3'h2
`define TSBE_ENV_BPSK       3'h3
`define TSBE_ENV_RZ_HALF    3'h4
`define TSBE_ENV_RZ_ALT     3'h5
`define TSBE_PULSE_NONE     2'h0
`define TSBE_PULSE_START    2'h1
`define TSBE_PULSE_HALF     2'h2
`define TSBE_PULSE_Q3       2'h3
`define TSBE_RATE_MIN       3'h2
`define TSBE_RATE_MAX       3'h7
`define TSBE_CLK_HZ         125000000
`define TSBE_RATE848_HZ     848000
`define TSBE_BIT848_CYC     (`TSBE_CLK_HZ / `TSBE_RATE848_HZ)
`endif

// [logic/tsbe_tx_shaper.v]
// transmit symbol shaping: registers, burst insertion, pattern stepping
// assumes byte register port in the core clock domain, data bits from the
// framing logic with valid/ready, output to the RF driver
`timescale 1ns/10ps
`include "tsbe_defs.vh"
module tsbe_tx_shaper #(
  parameter BIT848_CYC = `TSBE_BIT848_CYC
) (
  clk,
  arst_n,
  regAddr,
  regWrData,
  regWrEn,
  regRdEn,
  regRdData,
  burstLength,
  txValid,
  txBit,
  txPair23,
  txReady,
  txOut,
  txActive
);
  input  wire       clk;
  input  wire       arst_n;
  input  wire [7:0] regAddr;
  input  wire [7:0] regWrData;
  input  wire       regWrEn;
  input  wire       regRdEn;
  output reg  [7:0] regRdData;
  input  wire [7:0] burstLength;
  input  wire       txValid;
  input  wire       txBit;
  input  wire       txPair23;
  output reg        txReady;
  output reg        txOut;
  output reg        txActive;

  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_BURST = 3'h2;
  localparam [2:0] ST_PAT   = 3'h4;

  reg [7:0]  freq_r, sym0h_r, sym0l_r, sym1h_r, sym1l_r, sym2_r, sym3_r;
  reg [7:0]  len10_r, len32_r, burst_r, mod10_r, mod32_r;
  reg [2:0]  state_r;
  reg [15:0] pat_r;
  reg [3:0]  patLeft_r;
  reg [7:0]  burstLeft_r;
  reg        pair23_r;
  reg        burstPol_r;
  reg        burstOnly_r;
  reg        prevBit_r;
  reg [15:0] phase_r;
  reg [15:0] scCnt_r;
  reg        sc_r;
  wire [7:0] modSel;
  wire [2:0] rateSel;
  wire [15:0] bitCyc;
  wire [15:0] scHalf;
  wire       bitEnd;
  wire [1:0] quarter;
  wire       shaped;

  // bit period in clocks; reserved codes run at the slowest rate
  function [15:0] bit_cycles;
    input [2:0] code;
    reg   [2:0] c;
    begin
      c = (code < `TSBE_RATE_MIN) ? `TSBE_RATE_MIN : code;
      bit_cycles = BIT848_CYC[15:0] << (`TSBE_RATE_MAX - c);
    end
  endfunction

  function [1:0] quarter_of;
    input [15:0] ph;
    input [15:0] cyc;
    begin
      if (ph < (cyc >> 2))
        quarter_of = 2'h0;
      else if (ph < (cyc >> 1))
        quarter_of = 2'h1;
      else if (ph < ((cyc >> 1) + (cyc >> 2)))
        quarter_of = 2'h2;
      else
        quarter_of = 2'h3;
    end
  endfunction

  assign modSel  = pair23_r ? mod32_r : mod10_r;
  assign rateSel = pair23_r ? freq_r[6:4] : freq_r[2:0];
  assign bitCyc  = bit_cycles(rateSel);
  assign scHalf  = (pair23_r ? freq_r[`TSBE_BIT_SC23]
                             : freq_r[`TSBE_BIT_SC01])
                   ? (BIT848_CYC[15:0] >> 1) : BIT848_CYC[15:0];
  assign bitEnd  = (phase_r == bitCyc - 16'h0001);
  assign quarter = quarter_of(phase_r, bitCyc);

  tsbe_bit_shaper u_shaper (
    .bitVal    (pat_r[15]),
    .prevBit   (prevBit_r),
    .quarter   (quarter),
    .scLevel   (sc_r),
    .envSel    (modSel[2:0]),
    .pulseSel  (modSel[5:4]),
    .millerOn  (modSel[`TSBE_BIT_MILLER]),
    .rzAtStart (pair23_r),
    .invertOn  (modSel[`TSBE_BIT_INVERT]),
    .level     (shaped)
  );

  // register writes; reserved bits never store
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      freq_r  <= `TSBE_RST_VAL;
      sym0h_r <= `TSBE_RST_VAL;
      sym0l_r <= `TSBE_RST_VAL;
      sym1h_r <= `TSBE_RST_VAL;
      sym1l_r <= `TSBE_RST_VAL;
      sym2_r  <= `TSBE_RST_VAL;
      sym3_r  <= `TSBE_RST_VAL;
      len10_r <= `TSBE_RST_VAL;
      len32_r <= `TSBE_RST_VAL;
      burst_r <= `TSBE_RST_VAL;
      mod10_r <= `TSBE_RST_VAL;
      mod32_r <= `TSBE_RST_VAL;
    end else if (regWrEn) begin
      case (regAddr)
        `TSBE_ADDR_FREQ:  freq_r  <= regWrData;
        `TSBE_ADDR_SYM0H: sym0h_r <= regWrData;
        `TSBE_ADDR_SYM0L: sym0l_r <= regWrData;
        `TSBE_ADDR_SYM1H: sym1h_r <= regWrData;
        `TSBE_ADDR_SYM1L: sym1l_r <= regWrData;
        `TSBE_ADDR_SYM2:  sym2_r  <= regWrData;
        `TSBE_ADDR_SYM3:  sym3_r  <= regWrData;
        `TSBE_ADDR_LEN10: len10_r <= regWrData;
        `TSBE_ADDR_LEN32: len32_r <= regWrData & `TSBE_MASK_LEN32;
        `TSBE_ADDR_BURST: burst_r <= regWrData & `TSBE_MASK_BURST;
        `TSBE_ADDR_MOD10: mod10_r <= regWrData & `TSBE_MASK_MOD;
        `TSBE_ADDR_MOD32: mod32_r <= regWrData & `TSBE_MASK_MOD;
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe, unmapped reads zero
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      case (regAddr)
        `TSBE_ADDR_FREQ:  regRdData <= freq_r;
        `TSBE_ADDR_SYM0H: regRdData <= sym0h_r;
        `TSBE_ADDR_SYM0L: regRdData <= sym0l_r;
        `TSBE_ADDR_SYM1H: regRdData <= sym1h_r;
        `TSBE_ADDR_SYM1L: regRdData <= sym1l_r;
        `TSBE_ADDR_SYM2:  regRdData <= sym2_r;
        `TSBE_ADDR_SYM3:  regRdData <= sym3_r;
        `TSBE_ADDR_LEN10: regRdData <= len10_r;
        `TSBE_ADDR_LEN32: regRdData <= len32_r;
        `TSBE_ADDR_BURST: regRdData <= burst_r;
        `TSBE_ADDR_MOD10: regRdData <= mod10_r;
        `TSBE_ADDR_MOD32: regRdData <= mod32_r;
        default:          regRdData <= 8'h00;
      endcase
    end
  end

  // symbol sequencer
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r     <= ST_IDLE;
      pat_r       <= 16'h0000;
      patLeft_r   <= 4'h0;
      burstLeft_r <= 8'h00;
      pair23_r    <= 1'b0;
      burstPol_r  <= 1'b0;
      burstOnly_r <= 1'b0;
      prevBit_r   <= 1'b0;
      phase_r     <= 16'h0000;
      scCnt_r     <= 16'h0000;
      sc_r        <= 1'b0;
      txReady     <= 1'b0;
      txOut       <= 1'b0;
      txActive    <= 1'b0;
    end else begin
      if (state_r == ST_IDLE || scCnt_r == scHalf - 16'h0001) begin
        scCnt_r <= 16'h0000;
        sc_r    <= (state_r == ST_IDLE) ? 1'b0 : ~sc_r;
      end else begin
        scCnt_r <= scCnt_r + 16'h0001;
      end
      case (state_r)
        ST_IDLE: begin
          txReady  <= 1'b1;
          txOut    <= 1'b0;
          txActive <= 1'b0;
          phase_r  <= 16'h0000;
          if (txValid && txReady) begin
            txReady  <= 1'b0;
            pair23_r <= txPair23;
            case ({txPair23, txBit})
              2'b00: begin
                pat_r       <= {sym0h_r, sym0l_r};
                patLeft_r   <= len10_r[3:0];
                burstPol_r  <= burst_r[`TSBE_BIT_POL_S0];
                burstOnly_r <= burst_r[`TSBE_BIT_ALONE_S0];
                burstLeft_r <= burst_r[`TSBE_BIT_ON_S0] ? burstLength
                                                        : 8'h00;
                state_r     <= (burst_r[`TSBE_BIT_ON_S0] &&
                                burstLength != 8'h00) ? ST_BURST
                             : burst_r[`TSBE_BIT_ALONE_S0] ? ST_IDLE
                             : ST_PAT;
              end
              2'b01: begin
                pat_r       <= {sym1h_r, sym1l_r};
                patLeft_r   <= len10_r[7:4];
                burstPol_r  <= burst_r[`TSBE_BIT_POL_S1];
                burstOnly_r <= burst_r[`TSBE_BIT_ALONE_S1];
                burstLeft_r <= burst_r[`TSBE_BIT_ON_S1] ? burstLength
                                                        : 8'h00;
                state_r     <= (burst_r[`TSBE_BIT_ON_S1] &&
                                burstLength != 8'h00) ? ST_BURST
                             : burst_r[`TSBE_BIT_ALONE_S1] ? ST_IDLE
                             : ST_PAT;
              end
              2'b10: begin
                pat_r       <= {sym2_r, 8'h00};
                patLeft_r   <= {1'b0, len32_r[2:0]};
                burstOnly_r <= 1'b0;
                state_r     <= ST_PAT;
              end
              default: begin
                pat_r       <= {sym3_r, 8'h00};
                patLeft_r   <= {1'b0, len32_r[6:4]};
                burstOnly_r <= 1'b0;
                state_r     <= ST_PAT;
              end
            endcase
          end
        end
        ST_BURST: begin
          txActive <= 1'b1;
          txOut    <= burstPol_r ^ modSel[`TSBE_BIT_INVERT];
          phase_r  <= bitEnd ? 16'h0000 : phase_r + 16'h0001;
          if (bitEnd) begin
            burstLeft_r <= burstLeft_r - 8'h01;
            if (burstLeft_r == 8'h01)
              state_r <= burstOnly_r ? ST_IDLE : ST_PAT;
          end
        end
        ST_PAT: begin
          txActive <= 1'b1;
          txOut    <= shaped;
          phase_r  <= bitEnd ? 16'h0000 : phase_r + 16'h0001;
          if (bitEnd) begin
            prevBit_r <= pat_r[15];
            pat_r     <= {pat_r[14:0], 1'b0};
            patLeft_r <= patLeft_r - 4'h1;
            if (patLeft_r == 4'h0)
              state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// [verification/tsbe_card_model.sv]
// far side model: records the modulation level seen by the card
// assumes registered outputs, sampled on the rising edge
`timescale 1ns/10ps
module tsbe_card_model (
  input wire logic clk,
  input wire logic txActive,
  input wire logic txOut
);
  logic got[$];
  always @(posedge clk) begin
    if (txActive) begin
      got.push_back(txOut);
    end
  end
endmodule

// [verification/tsbe_tx_shaper_asserts.sv]
// port checks of the transmit symbol shaper
// assumes binding onto tsbe_tx_shaper, one clock domain
`timescale 1ns/10ps
module tsbe_tx_shaper_asserts #(
  parameter BIT848_CYC = 147
) (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic [7:0] burstLength,
  input wire logic       txValid,
  input wire logic       txBit,
  input wire logic       txPair23,
  input wire logic       txReady,
  input wire logic       txOut,
  input wire logic       txActive
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_ready_drop: assert property (txValid && txReady |=> !txReady)
    else $error("ready did not drop after take");
  a_ready_idle: assert property (txReady |-> !txActive)
    else $error("ready while symbol active");
  a_ready_back: assert property ($fell(txActive) |=> txReady)
    else $error("ready late after symbol");
  a_idle_low: assert property (!txActive |-> !txOut)
    else $error("output high while idle");
  a_active_min: assert property ($rose(txActive) |-> txActive[*8])
    else $error("symbol shorter than one bit");
  a_rd_unmapped: assert property (regRdEn && (regAddr < 8'h4C ||
    regAddr > 8'h57) |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_burst_rsvd: assert property (regRdEn && regAddr == 8'h55
    |=> regRdData[7] == 1'b0 && regRdData[3] == 1'b0)
    else $error("burst reserved bits set");
  a_mod_rsvd: assert property (regRdEn && regAddr[7:1] == 7'h2B
    |=> !regRdData[7])
    else $error("modulation reserved bit set");
  a_rd_hold: assert property (!regRdEn |=> $stable(regRdData))
    else $error("read data changed without read");
  a_burst_store: assert property (regWrEn && regAddr == 8'h55 ##1
    regRdEn && !regWrEn && regAddr == 8'h55
    |=> regRdData == ($past(regWrData, 2) & 8'h77))
    else $error("burst control readback wrong");
  a_mod_store: assert property (regWrEn && regAddr == 8'h56 ##1
    regRdEn && !regWrEn && regAddr == 8'h56
    |=> regRdData == ($past(regWrData, 2) & 8'h7F))
    else $error("modulation readback wrong");
endmodule
bind tsbe_tx_shaper tsbe_tx_shaper_asserts #(.BIT848_CYC(BIT848_CYC)) u_chk (
  .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
  .burstLength(burstLength), .txValid(txValid), .txBit(txBit),
  .txPair23(txPair23), .txReady(txReady), .txOut(txOut),
  .txActive(txActive));

// [verification/tsbe_tx_shaper_tb.sv]
// self-checking bench of the transmit symbol shaper
// assumes short bits (8 clocks at rate code 7) via BIT848_CYC
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %0t got %0h exp %0h", $time, g, e); end end
module tsbe_tx_shaper_tb;
  logic       clk, arst_n, regWrEn, regRdEn, txValid, txBit, txPair23;
  logic [7:0] regAddr, regWrData, burstLength, regRdData, d, a, bc, mdv;
  logic       txReady, txOut, txActive, pr, inv, mil, prev, on, alo, pol;
  logic [2:0] env, rt;
  logic       scb;
  logic [1:0] pul;
  logic [3:0] len;
  logic [15:0] pat;
  logic       q[$];
  logic [7:0] fixA[5] = '{8'h60, 8'h54, 8'h55, 8'h56, 8'h57};
  int         err_total, checks_done, cyc, j, k, b, ph, nb, seed, bcyc, sh;
  tsbe_tx_shaper #(.BIT848_CYC(8)) dut (.clk(clk), .arst_n(arst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .burstLength(burstLength),
    .txValid(txValid), .txBit(txBit), .txPair23(txPair23),
    .txReady(txReady), .txOut(txOut), .txActive(txActive));
  tsbe_card_model card (.clk(clk), .txActive(txActive), .txOut(txOut));
  always #4 clk = ~clk;
  task test_done;
    if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      test_done();
    end
  end
  // strobes stay up between back-to-back accesses; idle drops them
  task wr(input logic [7:0] ad, input logic [7:0] dv);
    regAddr = ad; regWrData = dv; regWrEn = 1'b1; regRdEn = 1'b0;
    @(negedge clk);
  endtask
  task rd(input logic [7:0] ad, output logic [7:0] dv);
    regAddr = ad; regRdEn = 1'b1; regWrEn = 1'b0;
    @(negedge clk);
    dv = regRdData;
  endtask
  task idle;
    regWrEn = 1'b0; regRdEn = 1'b0;
    @(negedge clk);
  endtask
  // clocks per bit with 8 clocks at the fastest code
  function automatic int bit_len(input logic [2:0] r);
    return 8 << (7 - ((r < 3'h2) ? 2 : r));
  endfunction
  task wait_ready;
    int n;
    n = 0;
    while (txReady !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
  endtask
  function automatic logic [7:0] mask(input logic [7:0] ad);
    if (ad == 8'h54 || ad == 8'h55) return 8'h77;
    if (ad == 8'h56 || ad == 8'h57) return 8'h7F;
    if (ad >= 8'h4C && ad <= 8'h53) return 8'hFF;
    return 8'h00;
  endfunction
  function automatic logic lv(logic bv, logic p, logic [1:0] qt,
    logic [2:0] e, logic [1:0] pu, logic m, logic p23, logic iv, logic s);
    logic v;
    case (e)
      3'h0: v = bv;
      3'h1: v = bv ^ qt[1];
      3'h2: v = (bv ^ qt[1]) & s;
      3'h3: v = bv ^ s;
      3'h4: v = bv & qt[1];
      3'h5: v = p23 ? bv & !qt[1] : bv & qt[1];
      default: v = 1'b0;
    endcase
    if (pu != 2'h0 && qt != ((pu == 2'h1) ? 2'h0 : pu)) v = 1'b0;
    if (m) v = bv ? (qt == 2'h2) : (!p && qt == 2'h0);
    return v ^ iv;
  endfunction
  initial begin
    clk = 0; arst_n = 0; regAddr = 0; regWrData = 0; regWrEn = 0;
    regRdEn = 0; burstLength = 0; txValid = 0; txBit = 0; txPair23 = 0;
    prev = 0;
    seed = $urandom(89);
    repeat (10) @(negedge clk);
    arst_n = 1;
    @(negedge clk);
    for (j = 8'h4C; j <= 8'h57; j++) begin
      rd(j[7:0], d);
      `CHK(d, 8'h00)
    end
    for (j = 0; j < 20; j++) begin
      a = (j < 5) ? fixA[j] : 8'h4C + 8'($urandom % 12);
      d = (j < 5) ? 8'hFF : 8'($urandom);
      wr(a, d);
      rd(a, mdv);
      `CHK(mdv, d & mask(a))
    end
    for (k = 0; k < 40; k++) begin
      pr = $urandom; txBit = $urandom; env = $urandom; pul = $urandom;
      inv = $urandom; bc = 8'($urandom) & 8'h77; len = $urandom;
      pat = $urandom; burstLength = $urandom % 4;
      rt = 3'h5 + 3'($urandom % 3); scb = $urandom;
      mil = (pul == 2'h1) && ($urandom % 2 == 1);
      if (mil) env = 3'h0;
      if (k == 0) begin pr = 0; bc = 8'h11; len = 4'hF; burstLength = 3; end
      if (k == 1) begin pr = 0; bc = 8'h22; end
      if (k == 2) begin pr = 1; len = 4'h0; env = 3'h6; mil = 0; end
      if (k == 3) begin pr = 0; env = 3'h7; mil = 0; bc = 8'h77; end
      if (k == 4) begin pr = 0; rt = 3'h1; bc = 8'h00; len = 4'h1; end
      if (k == 4) burstLength = 0;
      mdv = {1'b0, mil, pul, inv, env};
      wr(8'h4C, {scb, rt, scb, rt});
      bcyc = bit_len(rt);
      sh = scb ? 4 : 8;
      wr(8'h55, bc);
      wr(pr ? 8'h57 : 8'h56, mdv);
      wr(8'h4D, pat[15:8]); wr(8'h4E, pat[7:0]);
      wr(8'h4F, pat[15:8]); wr(8'h50, pat[7:0]);
      wr(8'h51, pat[15:8]); wr(8'h52, pat[15:8]);
      wr(8'h53, {len, len}); wr(8'h54, {1'b0, len[2:0], 1'b0, len[2:0]});
      {pol, alo, on} = txBit ? bc[6:4] : bc[2:0];
      q.delete();
      if (!pr && on && burstLength != 0)
        repeat (burstLength * bcyc) q.push_back(pol ^ inv);
      nb = pr ? len[2:0] + 1 : len + 1;
      // pattern leaves msb first; subcarrier starts low with the symbol
      if (pr || !alo) begin
        for (b = 15; b > 15 - nb; b--) begin
          for (ph = 0; ph < bcyc; ph++)
            q.push_back(lv(pat[b], prev, 2'(ph * 4 / bcyc), env, pul,
              mil, pr, inv, ((q.size() / sh) % 2) == 1));
          prev = pat[b];
        end
      end
      idle();
      wait_ready();
      card.got.delete();
      txPair23 = pr; txValid = 1'b1;
      @(negedge clk);
      txValid = 1'b0;
      wait_ready();
      `CHK(card.got.size(), q.size())
      if (card.got.size() == q.size())
        for (j = 0; j < q.size(); j++) `CHK(card.got[j], q[j])
    end
    test_done();
  end
endmodule
